// file: core/bta_defs.vh
`ifndef BTA_DEFS_VH
`define BTA_DEFS_VH

// ************************************************************
// Instruction register.
// ************************************************************
`define BTA_IR_LEN        2
`define BTA_IR_EXTEST     2'h0
`define BTA_IR_SAMPLE     2'h1
`define BTA_IR_SPARE      2'h2
`define BTA_IR_BYPASS     2'h3
`define BTA_IR_RESET_VAL  2'h3
`define BTA_IR_CAPTURE    2'h1

// ************************************************************
// Pin counts.
// ************************************************************
`define BTA_N_IN          4
`define BTA_N_OUT         4
`define BTA_N_BIDI        2
`define BTA_N_SYNC        15

// ************************************************************
// Boundary chain layout, bit 0 nearest the serial output.
// ************************************************************
`define BTA_BSR_LEN       14
`define BTA_BSR_IN_LO     0
`define BTA_BSR_BIN_LO    4
`define BTA_BSR_OUT_LO    6
`define BTA_BSR_BOUT_LO   10
`define BTA_BSR_BOE_LO    12

// ************************************************************
// Synchroniser vector layout.
// ************************************************************
`define BTA_SY_IN_LO      0
`define BTA_SY_BIDI_LO    4
`define BTA_SY_OUTRB_LO   6
`define BTA_SY_TCK        10
`define BTA_SY_TMS        11
`define BTA_SY_TDI        12
`define BTA_SY_TEST       13
`define BTA_SY_TRST_N     14

`endif

// file: core/bta_top.v
`timescale 1ns/1ps
`include "bta_defs.vh"

// What this block does
// - Instruction register all ones selects the bypass path from serial in to out.
// - Bypass is one stage capturing serial input, muxed onto serial output.
// - Controller state advances only on test clock rising edges, standard diagram.
// - Shift selects, update strobe and serial output change on test clock falling edges.
// - Each controller branch follows the sampled level of mode select.
// - Test port pins: clock, mode select, data in, data out, optional reset.
// - Each output cell muxes system value or scan-held value onto the pin.
// - Mapping mode drives outputs from input data while the test pin is high.
// - Surplus inputs merge through OR gates, the two bidirectional pins onto outputs 0 and 1.
// - In mapping mode each bidirectional pin acts only as an input.
// - Input-only mode ORs all inputs onto one observation pin.
// - Bidirectional pins are released to high impedance during input-only test.
// - Extended input-only test disables every output driver and observes it.
// - Instruction capture loads one into the low bit, zero into the next.
// - Test reset and system reset force the instruction to bypass.
// - During instruction shift the serial output carries instruction register bits.
module bta_top (
   input  wire                      MCLK,
   input  wire                      SYS_RST,
   input  wire                      TCK,
   input  wire                      TMS,
   input  wire                      TDI,
   input  wire                      TRST_N,
   output reg                       TDO,
   output reg                       TDO_OE,
   input  wire                      TEST_PIN,
   input  wire                      MAP_SEL,
   input  wire [`BTA_N_IN-1:0]      PIN_IN,
   input  wire [`BTA_N_OUT-1:0]     PIN_OUT_I,
   output reg  [`BTA_N_OUT-1:0]     PIN_OUT_O,
   output reg  [`BTA_N_OUT-1:0]     PIN_OUT_OE,
   input  wire [`BTA_N_BIDI-1:0]    BIDI_I,
   output reg  [`BTA_N_BIDI-1:0]    BIDI_O,
   output reg  [`BTA_N_BIDI-1:0]    BIDI_OE,
   output reg                       OBSERVATION_OUTPUT_PIN,
   input  wire [`BTA_N_OUT-1:0]     CORE_OUT,
   input  wire [`BTA_N_BIDI-1:0]    CORE_BIDI_O,
   input  wire [`BTA_N_BIDI-1:0]    CORE_BIDI_OE,
   output reg  [`BTA_N_IN-1:0]      CORE_IN,
   output reg  [`BTA_N_BIDI-1:0]    CORE_BIDI_IN
);

   localparam [3:0] ST_RESET   = 4'h0;
   localparam [3:0] ST_IDLE    = 4'h1;
   localparam [3:0] ST_SEL_DR  = 4'h2;
   localparam [3:0] ST_CAP_DR  = 4'h3;
   localparam [3:0] ST_SH_DR   = 4'h4;
   localparam [3:0] ST_EX1_DR  = 4'h5;
   localparam [3:0] ST_PA_DR   = 4'h6;
   localparam [3:0] ST_EX2_DR  = 4'h7;
   localparam [3:0] ST_UP_DR   = 4'h8;
   localparam [3:0] ST_SEL_IR  = 4'h9;
   localparam [3:0] ST_CAP_IR  = 4'ha;
   localparam [3:0] ST_SH_IR   = 4'hb;
   localparam [3:0] ST_EX1_IR  = 4'hc;
   localparam [3:0] ST_PA_IR   = 4'hd;
   localparam [3:0] ST_EX2_IR  = 4'he;
   localparam [3:0] ST_UP_IR   = 4'hf;

   // ************************************************************
   // Input synchronisers.
   // ************************************************************
   reg  [`BTA_N_SYNC-1:0]   sync1;
   reg  [`BTA_N_SYNC-1:0]   sync2;
   reg                      tck_last;
   wire [`BTA_N_SYNC-1:0]   pin_raw;
   wire                     tck_rise;
   wire                     tck_fall;
   wire                     tms;
   wire                     tdi;
   wire                     test_on;
   wire                     tap_rst;
   wire [`BTA_N_IN-1:0]     in_s;
   wire [`BTA_N_BIDI-1:0]   bidi_s;
   wire [`BTA_N_OUT-1:0]    outrb_s;

   // Every pin except MAP_SEL and SYS_RST, the test clock included, passes two flip-flops before any logic reads it.
   assign pin_raw = {TRST_N, TEST_PIN, TDI, TMS, TCK, PIN_OUT_I, BIDI_I, PIN_IN};

   always @(posedge MCLK) begin
      if (SYS_RST) begin
         sync1    <= {`BTA_N_SYNC{1'b0}};
         sync2    <= {`BTA_N_SYNC{1'b0}};
         tck_last <= 1'b0;
      end else begin
         sync1    <= pin_raw;
         sync2    <= sync1;
         tck_last <= sync2[`BTA_SY_TCK];
      end
   end

   // A test clock edge is seen in the same system clock that it leaves the second flip-flop.
   assign tck_rise = sync2[`BTA_SY_TCK] & ~tck_last;
   assign tck_fall = ~sync2[`BTA_SY_TCK] & tck_last;
   assign tms      = sync2[`BTA_SY_TMS];
   assign tdi      = sync2[`BTA_SY_TDI];
   assign test_on  = sync2[`BTA_SY_TEST];
   assign tap_rst  = SYS_RST | ~sync2[`BTA_SY_TRST_N];
   assign in_s     = sync2[`BTA_SY_IN_LO +: `BTA_N_IN];
   assign bidi_s   = sync2[`BTA_SY_BIDI_LO +: `BTA_N_BIDI];
   assign outrb_s  = sync2[`BTA_SY_OUTRB_LO +: `BTA_N_OUT];

   // ************************************************************
   // Controller next state.
   // ************************************************************
   reg  [3:0] state;
   reg  [3:0] next_state;

   // Each branch follows the synchronised mode select as it stands at the test clock rise.
   always @* begin
      case (state)
         ST_RESET:  next_state = tms ? ST_RESET  : ST_IDLE;
         ST_IDLE:   next_state = tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  next_state = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: next_state = tms ? ST_UP_DR  : ST_PA_DR;
         ST_PA_DR:  next_state = tms ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: next_state = tms ? ST_UP_DR  : ST_SH_DR;
         ST_UP_DR:  next_state = tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: next_state = tms ? ST_RESET  : ST_CAP_IR;
         ST_CAP_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  next_state = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: next_state = tms ? ST_UP_IR  : ST_PA_IR;
         ST_PA_IR:  next_state = tms ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: next_state = tms ? ST_UP_IR  : ST_SH_IR;
         ST_UP_IR:  next_state = tms ? ST_SEL_DR : ST_IDLE;
         default:   next_state = ST_RESET;
      endcase
   end

   // ************************************************************
   // Scan registers on the test clock rising edge.
   // ************************************************************
   reg  [`BTA_IR_LEN-1:0]   ir;
   reg  [`BTA_IR_LEN-1:0]   ir_sh;
   reg  [`BTA_BSR_LEN-1:0]  bsr_sh;
   reg  [`BTA_BSR_LEN-1:0]  bsr_upd;
   reg                      bypass_bit;
   reg                      data_shift_select;
   reg                      instruction_shift_select;
   reg                      data_update_strobe;
   reg                      data_capture_clock;
   wire                     sel_bypass;
   wire                     extest;
   wire [`BTA_BSR_LEN-1:0]  bsr_cap;

   assign sel_bypass = (ir == `BTA_IR_BYPASS) | (ir == `BTA_IR_SPARE);
   assign extest     = (ir == `BTA_IR_EXTEST);
   assign bsr_cap    = {CORE_BIDI_OE, CORE_BIDI_O, CORE_OUT, bidi_s, in_s};

   // Data capture and both shifts follow the control levels registered at the previous falling edge; instruction capture decodes the state.
   always @(posedge MCLK) begin
      if (tap_rst) begin
         state      <= ST_RESET;
         ir_sh      <= `BTA_IR_RESET_VAL;
         bsr_sh     <= {`BTA_BSR_LEN{1'b0}};
         bypass_bit <= 1'b0;
      end else if (tck_rise) begin
         state <= next_state;
         if (state == ST_CAP_IR) begin
            ir_sh <= `BTA_IR_CAPTURE;
         end else if (instruction_shift_select) begin
            ir_sh <= {tdi, ir_sh[`BTA_IR_LEN-1:1]};
         end
         if (data_capture_clock) begin
            if (!data_shift_select) begin
               bypass_bit <= 1'b0;
               if (!sel_bypass) begin
                  bsr_sh <= bsr_cap;
               end
            end else if (sel_bypass) begin
               bypass_bit <= tdi;
            end else begin
               bsr_sh <= {tdi, bsr_sh[`BTA_BSR_LEN-1:1]};
            end
         end
      end
   end

   // ************************************************************
   // Control outputs, instruction update and serial out on the falling edge.
   // ************************************************************
   // The holding register reloads while the update strobe stands, so pins never see a shifting chain.
   always @(posedge MCLK) begin
      if (tap_rst) begin
         ir                       <= `BTA_IR_RESET_VAL;
         bsr_upd                  <= {`BTA_BSR_LEN{1'b0}};
         data_shift_select        <= 1'b0;
         instruction_shift_select <= 1'b0;
         data_update_strobe       <= 1'b0;
         data_capture_clock       <= 1'b0;
         TDO                      <= 1'b0;
         TDO_OE                   <= 1'b0;
      end else if (tck_fall) begin
         data_shift_select        <= (state == ST_SH_DR);
         instruction_shift_select <= (state == ST_SH_IR);
         data_update_strobe       <= (state == ST_UP_DR);
         data_capture_clock       <= (state == ST_CAP_DR) | (state == ST_SH_DR);
         TDO_OE                   <= (state == ST_SH_DR) | (state == ST_SH_IR);
         if (state == ST_SH_IR) begin
            TDO <= ir_sh[0];
         end else if (sel_bypass) begin
            TDO <= bypass_bit;
         end else begin
            TDO <= bsr_sh[0];
         end
         if (state == ST_UP_IR) begin
            ir <= ir_sh;
         end
      end else if (data_update_strobe && !sel_bypass) begin
         bsr_upd <= bsr_sh;
      end
   end

   // ************************************************************
   // Alternative test modes.
   // ************************************************************
   wire                     map_mode;
   wire                     inonly_mode;
   wire [`BTA_N_OUT-1:0]    map_data;
   wire [3:0]               or_grp;
   wire                     observe;

   assign map_mode    = test_on & MAP_SEL;
   assign inonly_mode = test_on & ~MAP_SEL;

   // Six mapped inputs share four outputs, so the bidirectional pins fold in through OR gates.
   assign map_data[0] = in_s[0] | bidi_s[0];
   assign map_data[1] = in_s[1] | bidi_s[1];
   assign map_data[2] = in_s[2];
   assign map_data[3] = in_s[3];

   // Input-only mode sees every input, bidirectional and read-back output pin on one line.
   assign or_grp[0] = |in_s;
   assign or_grp[1] = |bidi_s;
   assign or_grp[2] = |outrb_s;
   assign or_grp[3] = 1'b0;
   assign observe   = ~(&(~or_grp));

   // ************************************************************
   // Pin drivers.
   // ************************************************************
   // Test modes win over the scan instruction, and a test reset returns these drivers to system values by forcing bypass.
   genvar gi;
   generate
      for (gi = 0; gi < `BTA_N_OUT; gi = gi + 1) begin : g_out
         always @(posedge MCLK) begin
            if (SYS_RST) begin
               PIN_OUT_O[gi]  <= 1'b0;
               PIN_OUT_OE[gi] <= 1'b0;
            end else if (map_mode) begin
               PIN_OUT_O[gi]  <= map_data[gi];
               PIN_OUT_OE[gi] <= 1'b1;
            end else if (inonly_mode) begin
               PIN_OUT_O[gi]  <= 1'b0;
               PIN_OUT_OE[gi] <= 1'b0;
            end else begin
               PIN_OUT_O[gi]  <= extest ? bsr_upd[`BTA_BSR_OUT_LO + gi] : CORE_OUT[gi];
               PIN_OUT_OE[gi] <= 1'b1;
            end
         end
      end
      for (gi = 0; gi < `BTA_N_BIDI; gi = gi + 1) begin : g_bidi
         always @(posedge MCLK) begin
            if (SYS_RST) begin
               BIDI_O[gi]  <= 1'b0;
               BIDI_OE[gi] <= 1'b0;
            end else if (test_on) begin
               BIDI_O[gi]  <= 1'b0;
               BIDI_OE[gi] <= 1'b0;
            end else if (extest) begin
               BIDI_O[gi]  <= bsr_upd[`BTA_BSR_BOUT_LO + gi];
               BIDI_OE[gi] <= bsr_upd[`BTA_BSR_BOE_LO + gi];
            end else begin
               BIDI_O[gi]  <= CORE_BIDI_O[gi];
               BIDI_OE[gi] <= CORE_BIDI_OE[gi];
            end
         end
      end
   endgenerate

   always @(posedge MCLK) begin
      if (SYS_RST) begin
         OBSERVATION_OUTPUT_PIN <= 1'b0;
         CORE_IN                <= {`BTA_N_IN{1'b0}};
         CORE_BIDI_IN           <= {`BTA_N_BIDI{1'b0}};
      end else begin
         OBSERVATION_OUTPUT_PIN <= inonly_mode & observe;
         CORE_IN                <= in_s;
         CORE_BIDI_IN           <= bidi_s;
      end
   end

endmodule // bta_top

// file: tb/bta_top_asserts.sv
`timescale 1ns/1ps
// ****
// Port checker.
// ****
module bta_chk (
   input wire logic       MCLK,
   input wire logic       SYS_RST,
   input wire logic       TCK,
   input wire logic       TRST_N,
   input wire logic       TDO,
   input wire logic       TDO_OE,
   input wire logic       TEST_PIN,
   input wire logic       MAP_SEL,
   input wire logic [3:0] PIN_IN,
   input wire logic [3:0] PIN_OUT_I,
   input wire logic [3:0] PIN_OUT_O,
   input wire logic [3:0] PIN_OUT_OE,
   input wire logic [1:0] BIDI_I,
   input wire logic [1:0] BIDI_OE,
   input wire logic       OBSERVATION_OUTPUT_PIN,
   input wire logic [3:0] CORE_OUT
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (SYS_RST);
   wire       io_m  = TEST_PIN & MAP_SEL;
   wire       io_o  = TEST_PIN & ~MAP_SEL;
   wire [3:0] m_exp = {PIN_IN[3:2], PIN_IN[1:0] | BIDI_I};
   wire       o_exp = |{PIN_IN, BIDI_I, PIN_OUT_I};
   AST_TDO_EDGE: assert property (($changed(TDO) || $changed(TDO_OE)) |-> !TCK)
      else $error("serial out moved with test clock high");
   AST_TRST: assert property ((!TRST_N)[*4] |=> !TDO_OE && !TDO)
      else $error("test reset left serial out driven");
   AST_OBS_OFF: assert property ((!TEST_PIN)[*5] |=> !OBSERVATION_OUTPUT_PIN)
      else $error("observation pin high outside test");
   AST_IO_OFF: assert property (io_o[*5] |=> PIN_OUT_OE == 4'h0 && BIDI_OE == 2'h0)
      else $error("driver left on in input-only test");
   AST_MAP_OE: assert property (io_m[*5] |=> PIN_OUT_OE == 4'hf && BIDI_OE == 2'h0)
      else $error("mapping mode enables wrong");
   AST_MAP_DAT: assert property ((io_m && $stable(m_exp))[*5] |=> PIN_OUT_O == $past(m_exp))
      else $error("mapped output wrong");
   AST_OBS_OR: assert property ((io_o && $stable(o_exp))[*5] |=> OBSERVATION_OUTPUT_PIN == $past(o_exp))
      else $error("observation pin wrong");
   AST_NORMAL: assert property ((!TEST_PIN && !TRST_N && $stable(CORE_OUT))[*5] |=> PIN_OUT_O == $past(CORE_OUT))
      else $error("output pin not following system value");
   cover property (io_m[*5]);
   cover property (io_o[*5]);
   cover property ($rose(TDO_OE));
endmodule // bta_chk

bind bta_top bta_chk u_chk (.MCLK, .SYS_RST, .TCK, .TRST_N, .TDO, .TDO_OE, .TEST_PIN, .MAP_SEL, .PIN_IN,
   .PIN_OUT_I, .PIN_OUT_O, .PIN_OUT_OE, .BIDI_I, .BIDI_OE, .OBSERVATION_OUTPUT_PIN, .CORE_OUT);

// file: tb/bta_tester.sv
`timescale 1ns/1ps
// ****
// Tester model.
// ****
module bta_tester (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   output logic      trst_n,
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   logic last = 1'h0;
   wire  line_v = tdo_oe ? tdo : ~last;
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h0;
      trst_n = 1'h1;
   end
   always @(tdo or tdo_oe)
      if (tdo_oe)
         last = tdo;
   task automatic step(input logic m, input logic d, output logic q, output logic e);
      tms = m;
      tdi = d;
      #200 tck = 1'h1;
      #199 q = line_v;
      e = tdo_oe;
      #1 tck = 1'h0;
   endtask
   task automatic rst_link();
      trst_n = 1'h0;
      #400 trst_n = 1'h1;
   endtask
endmodule // bta_tester

// file: tb/bta_top_test.sv
`timescale 1ns/1ps
// ****
// Bench.
// ****
module bta_top_test;
   logic        mclk, sys_rst, tck, tms, tdi, trst_n, test_pin, map_sel, tdo, tdo_oe, obs, q, e;
   logic [3:0]  pin_in, pin_out_i, core_out, pin_out_o, pin_out_oe, core_in;
   logic [1:0]  bidi_i, core_bidi_o, core_bidi_oe, bidi_o, bidi_oe, core_bidi_in;
   logic [9:0]  v;
   logic [13:0] r;
   int          error_cnt = 0;
   int          checked = 0;
   logic [11:0] rows [6] = '{{1'h1, 4'h0, 2'h0, 4'h0, 1'h0}, {1'h1, 4'h5, 2'h2, 4'h7, 1'h0},
      {1'h1, 4'ha, 2'h1, 4'hb, 1'h0}, {1'h1, 4'h0, 2'h3, 4'h3, 1'h0},
      {1'h0, 4'h0, 2'h0, 4'h0, 1'h0}, {1'h0, 4'h9, 2'h3, 4'h0, 1'h1}};
   bta_top dut (.MCLK(mclk), .SYS_RST(sys_rst), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST_N(trst_n), .TDO(tdo),
      .TDO_OE(tdo_oe), .TEST_PIN(test_pin), .MAP_SEL(map_sel), .PIN_IN(pin_in), .PIN_OUT_I(pin_out_i),
      .PIN_OUT_O(pin_out_o), .PIN_OUT_OE(pin_out_oe), .BIDI_I(bidi_i), .BIDI_O(bidi_o), .BIDI_OE(bidi_oe),
      .OBSERVATION_OUTPUT_PIN(obs), .CORE_OUT(core_out), .CORE_BIDI_O(core_bidi_o),
      .CORE_BIDI_OE(core_bidi_oe), .CORE_IN(core_in), .CORE_BIDI_IN(core_bidi_in));
   bta_tester u_t (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe));
   initial begin
      mclk = 1'h0;
      forever #25 mclk = ~mclk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic apply(input logic t, input logic m, input logic [3:0] pi, input logic [1:0] bi,
                        input logic [3:0] oi);
      @(posedge mclk);
      {test_pin, map_sel, pin_in, bidi_i, pin_out_i} <= {t, m, pi, bi, oi};
      repeat (8) @(posedge mclk);
      #1;
   endtask
   task automatic load_ir(input logic [1:0] val);
      logic q0, e0;
      for (int k = 0; k < 5; k++) u_t.step(k == 1 || k == 2, 1'h0, q, e);
      u_t.step(1'h0, val[0], q0, e0);
      u_t.step(1'h1, val[1], q, e);
      chk({e, e0, q, q0}, 16'hd);
      u_t.step(1'h1, 1'h0, q, e);
      u_t.step(1'h0, 1'h0, q, e);
   endtask
   task automatic shift_dr(input int n, input logic [13:0] d);
      r = 14'h0;
      u_t.step(1'h1, 1'h0, q, e);
      u_t.step(1'h0, 1'h0, q, e);
      u_t.step(1'h0, 1'h0, q, e);
      for (int k = 0; k < n; k++) u_t.step(k == n - 1, d[k], r[k], e);
      u_t.step(1'h1, 1'h0, q, e);
      u_t.step(1'h0, 1'h0, q, e);
   endtask
   initial begin
      {sys_rst, test_pin, map_sel, pin_in, bidi_i, pin_out_i} = {1'h1, 12'h0};
      {core_out, core_bidi_o, core_bidi_oe} = 8'h96;
      repeat (5) @(posedge mclk);
      #1;
      chk({tdo_oe, obs, pin_out_oe, bidi_oe}, 16'h0);
      @(posedge mclk);
      sys_rst <= 1'h0;
      for (int i = 0; i < 6; i++) begin
         apply(1'h1, rows[i][11], rows[i][10:7], rows[i][6:5], 4'h0);
         if (rows[i][11])
            chk({pin_out_o, pin_out_oe, bidi_oe}, {rows[i][4:1], 4'hf, 2'h0});
         else
            chk({obs, pin_out_oe, bidi_oe}, {rows[i][0], 6'h0});
      end
      for (int k = 0; k < 10; k++) begin
         apply(1'h1, 1'h0, 4'h0, 2'h0, 4'h0);
         chk(obs, 1'h0);
         v = 10'h1 << k;
         apply(1'h1, 1'h0, v[3:0], v[5:4], v[9:6]);
         chk(obs, 1'h1);
      end
      apply(1'h0, 1'h0, 4'h6, 2'h1, 4'h0);
      chk({pin_out_o, bidi_o, bidi_oe, core_in, core_bidi_in, obs},
          {core_out, core_bidi_o, core_bidi_oe, pin_in, bidi_i, 1'h0});
      chk(pin_out_oe, 4'hf);
      #7;
      for (int k = 0; k < 5; k++) u_t.step(k == 1, 1'h0, q, e);
      chk(e, 1'h1);
      for (int k = 0; k < 5; k++) u_t.step(1'h1, 1'h0, q, e);
      chk(e, 1'h0);
      for (int k = 2; k < 4; k++) begin
         load_ir(k[1:0]);
         shift_dr(4, 14'hb);
         chk(r[3:0], 4'h6);
      end
      load_ir(2'h1);
      shift_dr(14, 14'h0);
      chk(r, {core_bidi_oe, core_bidi_o, core_out, bidi_i, pin_in});
      load_ir(2'h0);
      shift_dr(14, 14'h3940);
      #300;
      chk({pin_out_o, bidi_o, bidi_oe}, 8'h5b);
      u_t.rst_link();
      #300;
      chk({pin_out_o, bidi_o, bidi_oe, tdo_oe}, {core_out, core_bidi_o, core_bidi_oe, 1'h0});
      tally_and_finish();
   end
   initial begin
      #200000;
      error_cnt++;
      tally_and_finish();
   end
endmodule // bta_top_test
